// ===== rtl/fspm_pkg.sv
/*
 * Shared constants and types for the flash self-programming sequencer:
 * address map, boot size table, command encoding, write timing.
 * Assumes a single 100 MHz core clock; the write timer stands in for the RC oscillator.
 */
package fspm_pkg;
    localparam int unsigned        CLK_MHZ            = 100;
    // Write duration window in microseconds
    localparam int unsigned        WRITE_MIN_US       = 3700;
    localparam int unsigned        WRITE_MAX_US       = 4500;
    localparam int unsigned        WRITE_MIN_CYC      = WRITE_MIN_US * CLK_MHZ;
    localparam int unsigned        WRITE_MAX_CYC      = WRITE_MAX_US * CLK_MHZ;
    localparam int unsigned        WRITE_MID_CYC      = (WRITE_MIN_CYC + WRITE_MAX_CYC) / 2;
    localparam int unsigned        ARM_WINDOW_CYC     = 4;
    // Address geometry
    localparam int unsigned        COUNTER_TOP_BIT    = 11;
    localparam int unsigned        PAGE_WORD_TOP_BIT  = 4;
    localparam int unsigned        PTR_COUNTER_TOP    = 12;
    localparam int unsigned        PTR_PAGE_WORD_TOP  = 5;
    localparam int unsigned        PC_W               = COUNTER_TOP_BIT + 1;
    localparam int unsigned        WORD_W             = PAGE_WORD_TOP_BIT + 1;
    localparam int unsigned        PAGE_W             = PC_W - WORD_W;
    localparam int unsigned        PAGE_WORDS         = 32;
    localparam logic [11:0]        RWW_LAST           = 12'hbff;
    localparam logic [11:0]        HALTED_READ_REGION_FIRST         = 12'hc00;
    localparam logic [11:0]        BOOT_START_11      = 12'hf80;
    localparam logic [11:0]        BOOT_START_10      = 12'hf00;
    localparam logic [11:0]        BOOT_START_01      = 12'he00;
    localparam logic [11:0]        BOOT_START_00      = 12'hc00;
    // Control register bit positions
    localparam int unsigned        CTL_STORE_ENABLE   = 0;
    localparam int unsigned        CTL_PAGE_ERASE     = 1;
    localparam int unsigned        CTL_PAGE_WRITE     = 2;
    localparam int unsigned        CTL_REGION_READ_EN = 4;
    localparam int unsigned        CTL_REGION_BUSY    = 6;
    localparam int unsigned        CTL_IRQ_ENABLE     = 7;
    // Controller register offsets
    localparam logic [2:0]         REG_CMD            = 3'h0;
    localparam logic [2:0]         REG_ZPTR           = 3'h1;
    localparam logic [2:0]         REG_DATA           = 3'h2;
    localparam logic [2:0]         REG_STATUS         = 3'h3;
    localparam logic [2:0]         REG_IRQ_STAT       = 3'h4;
    localparam logic [2:0]         REG_IRQ_MASK       = 3'h5;
    localparam logic [2:0]         REG_PC             = 3'h6;
    localparam logic [2:0]         REG_READ           = 3'h7;
    localparam logic [7:0]         CMD_FILL           = 8'h01;
    localparam logic [7:0]         CMD_ERASE          = 8'h03;
    localparam logic [7:0]         CMD_WRITE          = 8'h05;
    localparam logic [7:0]         CMD_RWW_EN         = 8'h11;

    typedef enum logic [3:0] {
        FSPM_IDLE  = 4'b0001,
        FSPM_ARMED = 4'b0010,
        FSPM_BUSY  = 4'b0100,
        FSPM_DONE  = 4'b1000
    } fspm_state_t;

    function automatic logic [11:0] fspm_boot_start(input logic [1:0] size);
        case (size)
            2'b11:   fspm_boot_start = BOOT_START_11;
            2'b10:   fspm_boot_start = BOOT_START_10;
            2'b01:   fspm_boot_start = BOOT_START_01;
            default: fspm_boot_start = BOOT_START_00;
        endcase
    endfunction : fspm_boot_start
endpackage : fspm_pkg

// ===== rtl/fspm_if.sv
/*
 * Link between the CPU-side store controller and the flash sequencer.
 * Assumes both ends share core_clk_i; the testbench ties the two modports.
 */
`timescale 1ns/10ps
interface fspm_if;
    logic        ctl_wr;       // Control register write strobe
    logic [7:0]  ctl_wdata;    // Control register write data
    logic [7:0]  ctl_rdata;    // Control register contents
    logic        spm_exec;     // Store instruction executed
    logic [15:0] z_ptr;        // Z pointer
    logic [15:0] word_data;    // r0 pair
    logic        lpm_rd;       // Load-from-program-memory request
    logic [7:0]  lpm_data;     // Byte returned, one cycle later
    logic [11:0] fetch_pc;     // CPU program counter
    logic        fetch_ok;     // Fetch at fetch_pc allowed
    logic        in_boot;      // fetch_pc lies in the boot section
    logic        eeprom_write_pending;

    modport device (
        input  ctl_wr, ctl_wdata, spm_exec, z_ptr, word_data, lpm_rd, fetch_pc,
        input  eeprom_write_pending,
        output ctl_rdata, lpm_data, fetch_ok, in_boot
    );
    modport host (
        output ctl_wr, ctl_wdata, spm_exec, z_ptr, word_data, lpm_rd, fetch_pc,
        output eeprom_write_pending,
        input  ctl_rdata, lpm_data, fetch_ok, in_boot
    );
endinterface : fspm_if

// ===== rtl/fspm_seq.sv
/*
 * Flash self-programming sequencer: control register, page buffer, flash
 * array model, write timer, region busy handling and fetch gating.
 * Assumes the host end drives the link on the same core clock.
 */
// The implementer's own choices: the strobed register port and the register addresses.
// Functional notes
// - Writes last between 3.7 and 4.5 ms
// - Boot size field picks boot start address
// - Words 0x000-0xBFF concurrent, rest halted region
// - Twelve bit word counter addresses flash
// - Thirty-two word pages, low five bits
// - Page number from pointer bits 12..6
// - Buffer index from pointer bits 5..1
// - Pointer bits 15..13 ignored
// - Pointer bit 0 selects read byte
// - Store enable held until operation completes
// - Software waits for EEPROM write idle
// - Busy region unreadable until re-enabled
// - Only halted region fetchable while writing
// - Store enable alone loads buffer word
// - Erase or write with store enable
// - Store executes within four cycles
`timescale 1ns/10ps
module fspm_seq #(
    parameter int unsigned WRITE_CYC = fspm_pkg::WRITE_MID_CYC
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    // Boot size fuse field
    input  wire logic        boot_size_hi_i,
    input  wire logic        boot_size_lo_i,
    // CPU link
    fspm_if.device           link,
    // Completion event
    output logic             done_o
);
    import fspm_pkg::*;

    fspm_state_t                state;
    logic [7:0]                 ctl;
    logic [2:0]                 arm_cnt;
    logic [22:0]                tmr;
    logic                       op_erase;
    logic [PAGE_W-1:0]          op_page;
    // Buffer and array carry no reset; contents are unknown until written
    logic [15:0]                pbuf  [PAGE_WORDS];
    logic [15:0]                flash [1 << PC_W];
    logic [7:0]                 lpm_q;
    logic                       fetch_q;
    logic                       boot_q;
    logic [PAGE_W-1:0]          z_page;
    logic [WORD_W-1:0]          z_word;
    logic [PC_W-1:0]            z_addr;
    logic                       cmd_ok;

    // Erase or write: the commands that run the timer
    function automatic logic timed_op(input logic [7:0] c);
        return c[CTL_PAGE_ERASE] || c[CTL_PAGE_WRITE];
    endfunction : timed_op

    // word lies in the concurrent read region
    function automatic logic in_rww(input logic [PC_W-1:0] a);
        return a <= RWW_LAST;
    endfunction : in_rww

    assign z_page = link.z_ptr[PTR_COUNTER_TOP:PTR_PAGE_WORD_TOP+1];
    assign z_word = link.z_ptr[PTR_PAGE_WORD_TOP:1];
    assign z_addr = {z_page, z_word};
    assign cmd_ok = link.spm_exec && state == FSPM_ARMED;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state    <= FSPM_IDLE;
            arm_cnt  <= 3'h0;
            tmr      <= 23'h0;
            op_erase <= 1'b0;
            op_page  <= '0;
        end else begin
            case (state)
                FSPM_IDLE: begin
                    if (link.ctl_wr && link.ctl_wdata[CTL_STORE_ENABLE]
                            && !link.eeprom_write_pending) begin
                        state   <= FSPM_ARMED;
                        arm_cnt <= 3'h0;
                    end
                end
                FSPM_ARMED: begin
                    if (cmd_ok) begin
                        if (timed_op(ctl)) begin
                            state    <= FSPM_BUSY;
                            tmr      <= 23'(WRITE_CYC - 1);
                            op_erase <= ctl[CTL_PAGE_ERASE];
                            op_page  <= z_page;
                        end else begin
                            state <= FSPM_DONE;
                        end
                    end else if (arm_cnt == 3'(ARM_WINDOW_CYC - 1)) begin
                        // Abandoned command still passes DONE so software sees it end
                        state <= FSPM_DONE;
                    end else begin
                        arm_cnt <= arm_cnt + 3'h1;
                    end
                end
                FSPM_BUSY: begin
                    if (tmr == 23'h0) begin
                        state <= FSPM_DONE;
                    end else begin
                        tmr <= tmr - 23'h1;
                    end
                end
                FSPM_DONE: state <= FSPM_IDLE;
                default:   state <= FSPM_IDLE;
            endcase
        end
    end

    // Control register; busy flag is hardware-owned
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl <= 8'h00;
        end else begin
            if (state == FSPM_IDLE && link.ctl_wr && !link.eeprom_write_pending) begin
                ctl[5:0]            <= link.ctl_wdata[5:0];
                ctl[CTL_IRQ_ENABLE] <= link.ctl_wdata[CTL_IRQ_ENABLE];
            end
            // busy set by erase or write
            if (cmd_ok && timed_op(ctl)) begin
                ctl[CTL_REGION_BUSY] <= 1'b1;
            end else if (cmd_ok && ctl[CTL_REGION_READ_EN] && state != FSPM_BUSY) begin
                ctl[CTL_REGION_BUSY] <= 1'b0;
            end
            if (state == FSPM_DONE) begin
                ctl[5:0] <= 6'h00;
            end
        end
    end

    // buffer load when only store enable set
    always_ff @(posedge core_clk_i) begin
        if (cmd_ok && ctl[5:0] == 6'(CMD_FILL)) begin
            pbuf[z_word] <= link.word_data;
        end
    end

    // Array update at the end of the timed operation
    always_ff @(posedge core_clk_i) begin
        if (state == FSPM_BUSY && tmr == 23'h0) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                flash[{op_page, WORD_W'(i)}] <= op_erase ? 16'hffff : pbuf[i];
            end
        end
    end

    // byte select; busy region reads back ones
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lpm_q <= 8'h00;
        end else if (link.lpm_rd) begin
            if (ctl[CTL_REGION_BUSY] && in_rww(z_addr)) begin
                lpm_q <= 8'hff;
            end else begin
                lpm_q <= link.z_ptr[0] ? flash[z_addr][15:8] : flash[z_addr][7:0];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fetch_q <= 1'b0;
        end else begin
            fetch_q <= !((state == FSPM_BUSY || ctl[CTL_REGION_BUSY])
                         && in_rww(link.fetch_pc));
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            boot_q <= 1'b0;
        end else begin
            boot_q <= link.fetch_pc >= fspm_boot_start({boot_size_hi_i, boot_size_lo_i});
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= state == FSPM_DONE;
        end
    end

    assign link.ctl_rdata = ctl;
    assign link.lpm_data  = lpm_q;
    assign link.fetch_ok  = fetch_q;
    assign link.in_boot   = boot_q;
endmodule : fspm_seq

// ===== rtl/fspm_host.sv
/*
 * CPU-side store controller: software registers, timed command sequence
 * toward the sequencer, completion interrupt.
 * Assumes the sequencer end shares core_clk_i.
 */
`timescale 1ns/10ps
module fspm_host (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    // Software register port
    input  wire logic [2:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic             irq_o,
    // EEPROM write in progress
    input  wire logic        eeprom_write_pending_i,
    // Link
    fspm_if.host             link
);
    import fspm_pkg::*;

    logic [7:0]  cmd;
    logic [15:0] zp;
    logic [15:0] dat;
    logic [11:0] pc;
    logic [1:0]  step;
    logic        irq_stat;
    logic        irq_mask;
    logic        prev_en;
    logic        lpm_req;
    logic        lpm_pend;
    logic [7:0]  lpm_byte;
    logic        ctl_wr_q;
    logic        spm_q;
    logic        ee_q;

    // Command sequence: write control, then store one cycle later
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step     <= 2'h0;
            ctl_wr_q <= 1'b0;
            spm_q    <= 1'b0;
            cmd      <= 8'h00;
        end else begin
            ctl_wr_q <= 1'b0;
            spm_q    <= 1'b0;
            case (step)
                2'h0: begin
                    // wait for idle sequencer and EEPROM
                    if (wr_i && addr_i == REG_CMD && !link.ctl_rdata[CTL_STORE_ENABLE]
                            && !eeprom_write_pending_i) begin
                        cmd      <= wdata_i[7:0];
                        ctl_wr_q <= 1'b1;
                        step     <= 2'h1;
                    end
                end
                2'h1: begin
                    spm_q <= 1'b1;
                    step  <= 2'h2;
                end
                default: step <= 2'h0;
            endcase
        end
    end

    // Software registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            zp       <= 16'h0000;
            dat      <= 16'h0000;
            pc       <= 12'h000;
            irq_mask <= 1'b0;
            lpm_req  <= 1'b0;
        end else begin
            lpm_req <= wr_i && addr_i == REG_READ;
            if (wr_i && addr_i == REG_ZPTR) begin
                zp <= wdata_i;
            end
            if (wr_i && addr_i == REG_DATA) begin
                dat <= wdata_i;
            end
            if (wr_i && addr_i == REG_PC) begin
                pc <= wdata_i[11:0];
            end
            if (wr_i && addr_i == REG_IRQ_MASK) begin
                irq_mask <= wdata_i[0];
            end
        end
    end

    // Completion sticky flag; a new completion wins over the clear
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_en  <= 1'b0;
            irq_stat <= 1'b0;
            irq_o    <= 1'b0;
            lpm_pend <= 1'b0;
            lpm_byte <= 8'h00;
            ee_q     <= 1'b0;
        end else begin
            prev_en  <= link.ctl_rdata[CTL_STORE_ENABLE];
            ee_q     <= eeprom_write_pending_i;
            lpm_pend <= lpm_req;
            if (lpm_pend) begin
                lpm_byte <= link.lpm_data;
            end
            if (prev_en && !link.ctl_rdata[CTL_STORE_ENABLE]) begin
                irq_stat <= 1'b1;
            end else if (wr_i && addr_i == REG_IRQ_STAT && wdata_i[0]) begin
                irq_stat <= 1'b0;
            end
            irq_o <= irq_stat && irq_mask;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                REG_CMD:      rdata_o <= {8'h00, cmd};
                REG_ZPTR:     rdata_o <= zp;
                REG_DATA:     rdata_o <= dat;
                REG_STATUS:   rdata_o <= {6'h00, link.in_boot, link.fetch_ok, link.ctl_rdata};
                REG_IRQ_STAT: rdata_o <= {15'h0000, irq_stat};
                REG_IRQ_MASK: rdata_o <= {15'h0000, irq_mask};
                REG_PC:       rdata_o <= {4'h0, pc};
                default:      rdata_o <= {8'h00, lpm_byte};
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    assign link.ctl_wr               = ctl_wr_q;
    assign link.ctl_wdata            = cmd;
    assign link.spm_exec             = spm_q;
    assign link.z_ptr                = zp;
    assign link.word_data            = dat;
    assign link.lpm_rd               = lpm_req;
    assign link.fetch_pc             = pc;
    assign link.eeprom_write_pending = ee_q;
endmodule : fspm_host

// ===== verif/fspm_checker.sv
/*
 * Link checker: write timing, command handshake, region gating, boot map.
 * Assumes instantiation beside fspm_if with the sequencer's fuse inputs.
 */
`timescale 1ns/10ps
module fspm_checker #(
    parameter int unsigned WRITE_CYC = 20
) (
    // Clock, reset, fuses
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic        boot_size_hi_i,
    input wire logic        boot_size_lo_i,
    // Link
    input wire logic        ctl_wr,
    input wire logic [7:0]  ctl_wdata,
    input wire logic [7:0]  ctl_rdata,
    input wire logic        spm_exec,
    input wire logic [15:0] z_ptr,
    input wire logic        lpm_rd,
    input wire logic [7:0]  lpm_data,
    input wire logic [11:0] fetch_pc,
    input wire logic        fetch_ok,
    input wire logic        in_boot,
    input wire logic        eeprom_write_pending
);
    logic [31:0] hold_cnt;
    logic [11:0] boot_start;

    always_comb begin
        case ({boot_size_hi_i, boot_size_lo_i})
            2'b11:   boot_start = 12'hf80;
            2'b10:   boot_start = 12'hf00;
            2'b01:   boot_start = 12'he00;
            default: boot_start = 12'hc00;
        endcase
    end

    // Cycles the store enable has stood, read at its fall
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            hold_cnt <= '0;
        else if (ctl_rdata[0])
            hold_cnt <= hold_cnt + 32'h1;
        else
            hold_cnt <= '0;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_write_time;
        $fell(ctl_rdata[0]) && $past(ctl_rdata[1] || ctl_rdata[2])
            |-> hold_cnt inside {[WRITE_CYC:WRITE_CYC + 4]};
    endproperty
    a_write_time: assert property (p_write_time) else $error("write time off");
    property p_fill_quick;
        $fell(ctl_rdata[0]) && !$past(ctl_rdata[1] || ctl_rdata[2]) |-> hold_cnt == 2;
    endproperty
    a_fill_quick: assert property (p_fill_quick) else $error("fill length off");
    property p_se_hold;
        $rose(ctl_rdata[0]) |-> ctl_rdata[0] [*2];
    endproperty
    a_se_hold: assert property (p_se_hold) else $error("store enable dropped");
    property p_exec_window;
        ctl_wr && ctl_wdata[0] |-> ##[1:4] spm_exec;
    endproperty
    a_exec_window: assert property (p_exec_window) else $error("store late");
    property p_no_cmd_busy;
        ctl_wr |-> !ctl_rdata[0];
    endproperty
    a_no_cmd_busy: assert property (p_no_cmd_busy) else $error("command while busy");
    property p_no_cmd_ee;
        ctl_wr |-> !eeprom_write_pending;
    endproperty
    a_no_cmd_ee: assert property (p_no_cmd_ee) else $error("command during eeprom");
    property p_busy_read;
        lpm_rd && ctl_rdata[6] && z_ptr[12:1] <= 12'hbff |=> lpm_data == 8'hff;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy region readable");
    property p_rww_gate;
        $past(ctl_rdata[6]) && $past(fetch_pc) < 12'hc00 |-> !fetch_ok;
    endproperty
    a_rww_gate: assert property (p_rww_gate) else $error("busy region fetched");
    property p_halted_read_region_fetch;
        $past(fetch_pc) >= 12'hc00 |-> fetch_ok;
    endproperty
    a_halted_read_region_fetch: assert property (p_halted_read_region_fetch) else $error("halted region blocked");
    property p_boot_member;
        in_boot == ($past(fetch_pc) >= $past(boot_start));
    endproperty
    a_boot_member: assert property (p_boot_member) else $error("boot membership off");

    c_erase: cover property ($fell(ctl_rdata[0]) && $past(ctl_rdata[1]));
    c_busy_read: cover property (lpm_rd && ctl_rdata[6]);
    c_gate: cover property ($past(ctl_rdata[6]) && !fetch_ok);
endmodule : fspm_checker

// ===== verif/flash_self_program_map_tb_top.sv
/*
 * Top testbench: host and sequencer joined by fspm_if, driven on the
 * host register port. Assumes a shortened write timer.
 */
`timescale 1ns/10ps
module flash_self_program_map_tb_top;
    import fspm_pkg::*;
    localparam int unsigned WCYC = 40;
    logic        core_clk_i;
    logic        reset_n_i;
    logic        bsz_hi;
    logic        bsz_lo;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        irq;
    logic        ee_pend;
    logic        done;
    int          dones;
    logic [31:0] seed;
    logic [15:0] mem [0:4095];
    int          mismatches;
    int          checked;

    fspm_if lnk ();
    fspm_seq #(.WRITE_CYC(WCYC)) fspm_seq_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .boot_size_hi_i(bsz_hi), .boot_size_lo_i(bsz_lo), .link(lnk.device), .done_o(done));
    fspm_host fspm_host_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
        .eeprom_write_pending_i(ee_pend), .link(lnk.host));
    fspm_checker #(.WRITE_CYC(WCYC)) fspm_checker_i (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .boot_size_hi_i(bsz_hi), .boot_size_lo_i(bsz_lo),
        .ctl_wr(lnk.ctl_wr), .ctl_wdata(lnk.ctl_wdata), .ctl_rdata(lnk.ctl_rdata),
        .spm_exec(lnk.spm_exec), .z_ptr(lnk.z_ptr), .lpm_rd(lnk.lpm_rd),
        .lpm_data(lnk.lpm_data), .fetch_pc(lnk.fetch_pc), .fetch_ok(lnk.fetch_ok),
        .in_boot(lnk.in_boot), .eeprom_write_pending(lnk.eeprom_write_pending));

    // Completion pulses, one per command taken
    always @(posedge core_clk_i) begin
        if (done === 1'b1)
            dones++;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [15:0] exp_byte(input logic [15:0] z);
        logic [15:0] w;
        w = mem[z[12:1]];
        return {8'h00, z[0] ? w[15:8] : w[7:0]};
    endfunction : exp_byte

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk_i);
        wr    <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [2:0] a, output logic [15:0] v);
        @(posedge core_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk_i);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rreg

    // Counts cycles until the store enable clears, bounded
    task automatic wait_idle(output int n);
        n = 0;
        repeat (2) @(posedge core_clk_i);
        #1;
        while (lnk.ctl_rdata[0] === 1'b1 && n < 5000) begin
            @(posedge core_clk_i);
            #1 n++;
        end
    endtask : wait_idle

    task automatic cmd(input logic [15:0] z, input logic [7:0] c, output int n);
        wreg(REG_ZPTR, z);
        wreg(REG_CMD, {8'h00, c});
        wait_idle(n);
    endtask : cmd

    task automatic rflash(input logic [15:0] z, output logic [15:0] v);
        wreg(REG_ZPTR, z);
        wreg(REG_READ, 16'h0000);
        repeat (3) @(posedge core_clk_i);
        rreg(REG_READ, v);
        v = {8'h00, v[7:0]};
    endtask : rflash

    task automatic gate(input logic [11:0] pc, input logic ok);
        wreg(REG_PC, {4'h0, pc});
        repeat (3) @(posedge core_clk_i);
        #1 check(16'(lnk.fetch_ok), 16'(ok));
    endtask : gate

    task automatic prog(input logic [6:0] pg);
        int          n;
        logic [15:0] v;
        logic [15:0] z;
        cmd({3'b111, pg, 6'h00}, CMD_ERASE, n);
        check(16'(n >= WCYC && n <= WCYC + 6), 16'h1);
        cmd(16'h0000, CMD_RWW_EN, n);
        for (int w = 0; w < 32; w++) begin
            seed = xs(seed);
            mem[{pg, w[4:0]}] = seed[15:0];
            wreg(REG_DATA, seed[15:0]);
            cmd({seed[18:16], pg, w[4:0], 1'b0}, CMD_FILL, n);
        end
        wreg(REG_ZPTR, {3'b000, pg, 6'h00});
        wreg(REG_CMD, {8'h00, CMD_WRITE});
        rflash({3'b000, pg, 6'h01}, v);
        check(v, 16'h00ff);
        gate({pg, 5'h00}, 1'b0);
        gate(12'hc00, 1'b1);
        wait_idle(n);
        rflash({3'b000, pg, 6'h02}, v);
        check(v, 16'h00ff);
        cmd(16'h0000, CMD_RWW_EN, n);
        for (int b = 0; b < 64; b++) begin
            seed = xs(seed);
            z = {seed[2:0], pg, b[5:0]};
            rflash(z, v);
            check(v, exp_byte(z));
        end
    endtask : prog

    function automatic logic [11:0] bstart(input logic [1:0] c);
        case (c)
            2'b11:   return 12'hf80;
            2'b10:   return 12'hf00;
            2'b01:   return 12'he00;
            default: return 12'hc00;
        endcase
    endfunction : bstart

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    initial begin
        #200000;
        mismatches++;
        complete_run();
    end

    initial begin
        logic [15:0] v;
        int          n;
        {reset_n_i, wr, rd, ee_pend, addr, wdata} = '0;
        {bsz_hi, bsz_lo} = 2'b00;
        seed = 32'h716a;
        mismatches = 0;
        checked = 0;
        dones = 0;
        repeat (12) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        wreg(REG_IRQ_MASK, 16'h0001);
        prog(7'h5f);
        check(16'(irq), 16'h1);
        wreg(REG_IRQ_STAT, 16'h0001);
        repeat (2) @(posedge core_clk_i);
        #1 check(16'(irq), 16'h0);
        seed = xs(seed);
        prog(7'(seed[15:0] % 16'd96));
        for (int c = 0; c < 4; c++) begin
            @(posedge core_clk_i);
            {bsz_hi, bsz_lo} <= c[1:0];
            gate(bstart(c[1:0]) - 12'h001, 1'b1);
            check(16'(lnk.in_boot), 16'h0);
            gate(bstart(c[1:0]), 1'b1);
            check(16'(lnk.in_boot), 16'h1);
        end
        wreg(REG_IRQ_MASK, 16'h0000);
        @(posedge core_clk_i);
        ee_pend <= 1'b1;
        wreg(REG_CMD, {8'h00, CMD_FILL});
        repeat (4) @(posedge core_clk_i);
        #1 check(16'(lnk.ctl_rdata[0]), 16'h0);
        @(posedge core_clk_i);
        ee_pend <= 1'b0;
        cmd(16'h0000, CMD_FILL, n);
        check(16'(irq), 16'h0);
        rreg(REG_IRQ_STAT, v);
        check(16'(v[0]), 16'h1);
        check(16'(dones), 16'(2 * (PAGE_WORDS + 4) + 1));
        complete_run();
    end
endmodule : flash_self_program_map_tb_top
